// ---- design/cmr_pkg.sv ----
// package for the converter management status register bank
// assumes a 16-bit register port driven by the management interface decoder
`default_nettype none
package cmr_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] REMOTE_VENDOR_MSG_HIGH_OFS     = 5'h1e;
   localparam logic [4:0] SWITCH_CONFIG_STATUS_THREE_OFS = 5'h1f;
   // ----------------------------------------------------------------
   // field positions in the control/status word
   // ----------------------------------------------------------------
   localparam int CHIP_SOFT_RESTART_BIT = 0;
   localparam int POWER_ALARM_MASK_BIT  = 1;
   localparam int TP_CHAIN_FAULT_BIT    = 2;
   localparam int FX_CHAIN_FAULT_BIT    = 3;
   localparam int SELFTEST_RUN_BIT      = 4;
   localparam int SELFTEST_GOOD_BIT     = 5;
   localparam int LOOP_EN_BIT           = 6;
   localparam int LOOP_TMO_MASK_BIT     = 7;
   localparam int LOOP_DONE_BIT         = 8;
   localparam int LOOP_PASS_BIT         = 9;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] VENDOR_MSG_RST = 16'h0000;
   localparam logic        CTRL_BIT_RST   = 1'b0;
   // ----------------------------------------------------------------
   // state carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] vendor_msg;
      logic        soft_restart;
      logic        power_alarm_mask;
      logic        auto_loop_check_en;
      logic        loop_end_timeout_mask;
      logic [15:0] rd_data;
   } cmr_state_s;
endpackage : cmr_pkg
`default_nettype wire

// ---- design/cmr_regs.sv ----
// management register bank: vendor message word and control/status word
// assumes a single-cycle register port from the serial management decoder
//
// What this block does
// - writing 1 to restart bit pulses a chip restart; bit self-clears, reads 0
// - restart leaves every register value here untouched
// - power_alarm_mask 1 suppresses power notice; 0 enables it; reset 0
// - bits 2 and 3 show twisted-pair and fiber buffer chain faults
// - bit 4 reads 1 while the buffer RAM self-test runs
// - bit 5 gives self-test result once over: 1 pass, 0 fail
// - auto_loop_check_en enables automatic loopback test; reset 0
// - timeout mask 1 blocks loopback-end maintenance frame on timer expiry
// - timeout mask 0 sends loopback-end maintenance frame on timer expiry
// - bit 8 reads 1 once auto loopback test finished, 0 while running
// - bit 9 gives auto loopback result: 1 pass, 0 fail
// - vendor message word is read-only, 16 bits, resets to zero
`default_nettype none
module cmr_regs (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [4:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic        vendor_msg_valid_in,
   input  wire logic [15:0] vendor_msg_in,
   input  wire logic        tp_chain_fault_in,
   input  wire logic        fx_chain_fault_in,
   input  wire logic        selftest_running_in,
   input  wire logic        selftest_good_in,
   input  wire logic        loop_check_done_in,
   input  wire logic        loop_check_pass_in,
   input  wire logic        loop_timer_expired_in,
   input  wire logic        power_abnormal_in,
   output logic             chip_restart_out,
   output logic             power_notice_out,
   output logic             auto_loop_check_en_out,
   output logic             loop_end_frame_send_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cmr_pkg::cmr_state_s state_ff;
   cmr_pkg::cmr_state_s nxt_state;
   logic [15:0]         status_word;
   logic                wr_ctrl;
   logic                wr_ok;
   logic                restart_wr;

   // status word assembly, reserved bits zero
   always_comb begin
      status_word = 16'h0000;
      status_word[cmr_pkg::CHIP_SOFT_RESTART_BIT] = 1'b0;
      status_word[cmr_pkg::POWER_ALARM_MASK_BIT]  = state_ff.power_alarm_mask;
      status_word[cmr_pkg::TP_CHAIN_FAULT_BIT]    = tp_chain_fault_in;
      status_word[cmr_pkg::FX_CHAIN_FAULT_BIT]    = fx_chain_fault_in;
      status_word[cmr_pkg::SELFTEST_RUN_BIT]      = selftest_running_in;
      status_word[cmr_pkg::SELFTEST_GOOD_BIT]     = selftest_good_in;
      status_word[cmr_pkg::LOOP_EN_BIT]           = state_ff.auto_loop_check_en;
      status_word[cmr_pkg::LOOP_TMO_MASK_BIT]     = state_ff.loop_end_timeout_mask;
      status_word[cmr_pkg::LOOP_DONE_BIT]         = loop_check_done_in;
      status_word[cmr_pkg::LOOP_PASS_BIT]         = loop_check_pass_in;
   end

   assign wr_ctrl = reg_wr_in && (reg_addr_in == cmr_pkg::SWITCH_CONFIG_STATUS_THREE_OFS);
   assign wr_ok   = wr_ctrl;
   assign restart_wr = wr_ctrl && reg_wdata_in[cmr_pkg::CHIP_SOFT_RESTART_BIT];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_state.soft_restart = 1'b0;
      if (vendor_msg_valid_in) begin
         nxt_state.vendor_msg = vendor_msg_in;
      end
      // only writable bits take the write; others ignored
      if (wr_ok) begin
         nxt_state.soft_restart = reg_wdata_in[cmr_pkg::CHIP_SOFT_RESTART_BIT];
         nxt_state.power_alarm_mask = reg_wdata_in[cmr_pkg::POWER_ALARM_MASK_BIT];
         nxt_state.auto_loop_check_en = reg_wdata_in[cmr_pkg::LOOP_EN_BIT];
         nxt_state.loop_end_timeout_mask = reg_wdata_in[cmr_pkg::LOOP_TMO_MASK_BIT];
      end
      // read data registered one cycle after the read strobe
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            cmr_pkg::REMOTE_VENDOR_MSG_HIGH_OFS:     nxt_state.rd_data = state_ff.vendor_msg;
            cmr_pkg::SWITCH_CONFIG_STATUS_THREE_OFS: nxt_state.rd_data = status_word;
            default:                                 nxt_state.rd_data = 16'h0000;
         endcase
      end
   end

   // registers; restart is an output only and never clears these
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff.vendor_msg            <= cmr_pkg::VENDOR_MSG_RST;
         state_ff.soft_restart          <= cmr_pkg::CTRL_BIT_RST;
         state_ff.power_alarm_mask      <= cmr_pkg::CTRL_BIT_RST;
         state_ff.auto_loop_check_en    <= cmr_pkg::CTRL_BIT_RST;
         state_ff.loop_end_timeout_mask <= cmr_pkg::CTRL_BIT_RST;
         state_ff.rd_data               <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata_out           = state_ff.rd_data;
   assign chip_restart_out        = state_ff.soft_restart;
   assign power_notice_out        = power_abnormal_in && !state_ff.power_alarm_mask;
   assign auto_loop_check_en_out  = state_ff.auto_loop_check_en;
   assign loop_end_frame_send_out = loop_timer_expired_in
                                    && !state_ff.loop_end_timeout_mask;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_restart_pulse;
      @(posedge clk_in) disable iff (rst_in)
         restart_wr |=> chip_restart_out ##1 (chip_restart_out == $past(restart_wr));
   endproperty
   a_restart_pulse: assert property (p_restart_pulse)
      else $error("restart not one pulse");

   property p_restart_keeps;
      @(posedge clk_in) disable iff (rst_in)
         chip_restart_out && !wr_ctrl |=> $stable(state_ff.power_alarm_mask)
            && $stable(state_ff.auto_loop_check_en);
   endproperty
   a_restart_keeps: assert property (p_restart_keeps)
      else $error("restart changed regs");

   property p_power_mask;
      @(posedge clk_in) disable iff (rst_in)
         state_ff.power_alarm_mask |-> !power_notice_out;
   endproperty
   a_power_mask: assert property (p_power_mask)
      else $error("power notice not masked");

   property p_fault_read;
      @(posedge clk_in) disable iff (rst_in)
         reg_rd_in && reg_addr_in == 5'h1f |=> reg_rdata_out[3:2]
            == $past({fx_chain_fault_in, tp_chain_fault_in});
   endproperty
   a_fault_read: assert property (p_fault_read) else $error("fault bits wrong");

   property p_selftest_read;
      @(posedge clk_in) disable iff (rst_in)
         reg_rd_in && reg_addr_in == 5'h1f |=> reg_rdata_out[5:4]
            == $past({selftest_good_in, selftest_running_in});
   endproperty
   a_selftest_read: assert property (p_selftest_read)
      else $error("self-test bits wrong");

   property p_loop_read;
      @(posedge clk_in) disable iff (rst_in)
         reg_rd_in && reg_addr_in == 5'h1f |=> reg_rdata_out[9:8]
            == $past({loop_check_pass_in, loop_check_done_in}) && reg_rdata_out[15:10] == 6'h00;
   endproperty
   a_loop_read: assert property (p_loop_read) else $error("loop bits wrong");

   property p_loop_en;
      @(posedge clk_in) disable iff (rst_in)
         wr_ctrl |=> auto_loop_check_en_out == $past(reg_wdata_in[6]);
   endproperty
   a_loop_en: assert property (p_loop_en) else $error("loop enable not taken");

   property p_tmo_frame;
      @(posedge clk_in) disable iff (rst_in)
         loop_timer_expired_in |-> loop_end_frame_send_out == !state_ff.loop_end_timeout_mask;
   endproperty
   a_tmo_frame: assert property (p_tmo_frame) else $error("end frame gating wrong");

   property p_vendor_ro;
      @(posedge clk_in) disable iff (rst_in)
         !vendor_msg_valid_in |=> $stable(state_ff.vendor_msg);
   endproperty
   a_vendor_ro: assert property (p_vendor_ro) else $error("vendor word changed");

   property p_vendor_load;
      @(posedge clk_in) disable iff (rst_in)
         vendor_msg_valid_in |=> state_ff.vendor_msg == $past(vendor_msg_in);
   endproperty
   a_vendor_load: assert property (p_vendor_load)
      else $error("vendor word not loaded");

   property p_vendor_read;
      @(posedge clk_in) disable iff (rst_in)
         reg_rd_in && reg_addr_in == cmr_pkg::REMOTE_VENDOR_MSG_HIGH_OFS
            |=> reg_rdata_out == $past(state_ff.vendor_msg);
   endproperty
   a_vendor_read: assert property (p_vendor_read)
      else $error("vendor word read wrong");

   property p_unmapped_zero;
      @(posedge clk_in) disable iff (rst_in)
         reg_rd_in && reg_addr_in != cmr_pkg::REMOTE_VENDOR_MSG_HIGH_OFS
            && reg_addr_in != cmr_pkg::SWITCH_CONFIG_STATUS_THREE_OFS
            |=> reg_rdata_out == 16'h0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");

   property p_restart_reads_zero;
      @(posedge clk_in) disable iff (rst_in)
         reg_rd_in && reg_addr_in == cmr_pkg::SWITCH_CONFIG_STATUS_THREE_OFS
            |=> !reg_rdata_out[cmr_pkg::CHIP_SOFT_RESTART_BIT];
   endproperty
   a_restart_reads_zero: assert property (p_restart_reads_zero)
      else $error("restart bit read as one");

   property p_power_open;
      @(posedge clk_in) disable iff (rst_in)
         power_abnormal_in && !state_ff.power_alarm_mask |-> power_notice_out;
   endproperty
   a_power_open: assert property (p_power_open)
      else $error("power notice missing");

   property p_tmo_send;
      @(posedge clk_in) disable iff (rst_in)
         loop_timer_expired_in && !state_ff.loop_end_timeout_mask |-> loop_end_frame_send_out;
   endproperty
   a_tmo_send: assert property (p_tmo_send)
      else $error("end frame not sent");

   c_restart:  cover property (@(posedge clk_in) disable iff (rst_in) chip_restart_out);
   c_loop_ok:  cover property (@(posedge clk_in) disable iff (rst_in)
                  auto_loop_check_en_out && loop_check_done_in && loop_check_pass_in);
   c_end_frame: cover property (@(posedge clk_in) disable iff (rst_in) loop_end_frame_send_out);
   c_vendor_read: cover property (@(posedge clk_in) disable iff (rst_in)
                  reg_rd_in && reg_addr_in == cmr_pkg::REMOTE_VENDOR_MSG_HIGH_OFS);
endmodule // cmr_regs
`default_nettype wire

// ---- verif/cmr_host.sv ----
// management host model driving the register port of the bank
// assumes one clock; strobes launched at the rising edge
`default_nettype none
module cmr_host (
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   output logic             wr_out,
   output logic             rd_out,
   output logic      [4:0]  addr_out,
   output logic      [15:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle port at time zero
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 5'h00;
      wdata_out = 16'h0000;
   end
   // one-cycle write strobe; released lines show the inverse
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   // one-cycle read strobe; data taken after the answering edge
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_in);
      rd_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask
endmodule // cmr_host
`default_nettype wire

// ---- verif/tb_converter_mgmt_status_regs.sv ----
// self-checking bench for the management register bank
// assumes cmr_host model on the register port; status inputs driven here
`default_nettype none
module tb_converter_mgmt_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0, rst_in = 1'b1, wr, rd, vmv, ro, pn, en, lf;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, vm, got, vexp, w;
   logic [7:0]  st; // tp fx run good done pass timer power
   logic [2:0]  ctl; // mask, loop enable, timeout mask
   int          error_cnt = 0, tests_run = 0;
   // ---------------------------------------------------------------
   // clock, instances, helpers
   // ---------------------------------------------------------------
   always #2 clk_in = ~clk_in;
   cmr_host i_cmr_host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata));
   cmr_regs i_cmr_regs (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .vendor_msg_valid_in(vmv), .vendor_msg_in(vm), .tp_chain_fault_in(st[0]),
      .fx_chain_fault_in(st[1]), .selftest_running_in(st[2]), .selftest_good_in(st[3]),
      .loop_check_done_in(st[4]), .loop_check_pass_in(st[5]),
      .loop_timer_expired_in(st[6]), .power_abnormal_in(st[7]), .chip_restart_out(ro),
      .power_notice_out(pn), .auto_loop_check_en_out(en), .loop_end_frame_send_out(lf));
   // expected control/status word
   function automatic logic [15:0] exp_ctl(input logic [2:0] c, input logic [7:0] s);
      return {6'h00, s[5], s[4], c[2], c[1], s[3], s[2], s[1], s[0], c[0], 1'b0};
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(82));
      vmv = 1'b0;
      vm = 16'h0000;
      st = 8'h00;
      ctl = 3'h0;
      vexp = 16'h0000;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      i_cmr_host.rd(5'h1f, got);
      chk("ctl_reset", 16'h0000, got);
      i_cmr_host.rd(5'h1e, got);
      chk("vmsg_reset", 16'h0000, got);
      i_cmr_host.rd(5'h05, got);
      chk("unmapped", 16'h0000, got);
      for (int i = 0; i < 24; i++) begin
         ctl = 3'($urandom);
         vexp = (i == 0) ? 16'hffff : 16'($urandom);
         @(posedge clk_in);
         st <= 8'($urandom);
         vm <= vexp;
         vmv <= 1'b1;
         @(posedge clk_in);
         vmv <= 1'b0;
         i_cmr_host.wr(5'h1e, ~vexp);
         w = (i == 1) ? 16'hfffe : 16'($urandom);
         w[7] = ctl[2];
         w[6] = ctl[1];
         w[1] = ctl[0];
         w[0] = 1'b0;
         i_cmr_host.wr(5'h1f, w);
         #1;
         chk("loop_en", 16'(ctl[1]), 16'(en));
         chk("notice", 16'(st[7] & ~ctl[0]), 16'(pn));
         chk("end_frame", 16'(st[6] & ~ctl[2]), 16'(lf));
         i_cmr_host.rd(5'h1f, got);
         chk("ctl", exp_ctl(ctl, st), got);
         if (got[4] === 1'b0) chk("good", 16'(st[3]), 16'(got[5]));
         i_cmr_host.rd(5'h1e, got);
         chk("vmsg", vexp, got);
      end
      i_cmr_host.wr(5'h1f, {8'h00, ctl[2], ctl[1], 4'h0, ctl[0], 1'b1});
      #1;
      chk("restart_hi", 16'h0001, 16'(ro));
      @(posedge clk_in);
      #1;
      chk("restart_lo", 16'h0000, 16'(ro));
      i_cmr_host.rd(5'h1f, got);
      chk("ctl_kept", exp_ctl(ctl, st), got);
      i_cmr_host.rd(5'h1e, got);
      chk("vmsg_kept", vexp, got);
      // second reset after settings were written
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      #1;
      chk("en_rereset", 16'h0000, 16'(en));
      i_cmr_host.rd(5'h1f, got);
      chk("ctl_rereset", exp_ctl(3'h0, st), got);
      i_cmr_host.rd(5'h1e, got);
      chk("vmsg_rereset", 16'h0000, got);
      end_of_test();
   end
   // hang guard
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
endmodule // tb_converter_mgmt_status_regs
`default_nettype wire
